//--- sim/program_watchdog_test.sv
// Self-checking bench of the program watchdog
`default_nettype none
module program_watchdog_test;
  timeunit 1ns;
  timeprecision 1ps;
  import program_watchdog_pkg::*;
  localparam int PER = 16;
  logic         i_clk            = 1'b0;
  logic         i_sys_rst        = 1'b1;
  logic         i_lso_clk        = 1'b0;
  logic         i_power_down     = 1'b0;
  logic         i_green_mode     = 1'b0;
  logic         i_avs_read       = 1'b0;
  logic         i_avs_write      = 1'b0;
  supv_option_t i_option         = OPT_ENABLE;
  logic [11:0]  i_avs_address    = 12'h0_000;
  logic [31:0]  i_avs_writedata  = 32'h0000_0000;
  logic [3:0]   i_avs_byteenable = 4'h1;
  wire  [31:0]  o_avs_readdata;
  wire          o_avs_waitrequest;
  wire          o_chip_reset;
  int           failures;
  int           check_count;
  int           cycles;
  int           pulses;
  logic [31:0]  rd;
  // Rows: option, power-down, green, whether the counter runs
  supv_option_t row_opt [6] = '{OPT_DISABLE, OPT_ENABLE, OPT_ENABLE, OPT_ENABLE,
                                OPT_ALWAYS_ON, supv_option_t'(2'd3)}; // Noisy-site choice
  logic         row_pd  [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic         row_gm  [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic         row_run [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

  program_watchdog #(.OVF_PERIODS(PER)) dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_lso_clk(i_lso_clk), .i_option(i_option),
    .i_power_down(i_power_down), .i_green_mode(i_green_mode),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_chip_reset(o_chip_reset));

  always #12.5 i_clk = ~i_clk;

  task automatic end_of_test();
    $display("failures=%0d check_count=%0d", failures, check_count);
    if (failures == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Counts chip reset pulses and cuts a hang short
  always @(posedge i_clk) begin
    cycles++;
    if (o_chip_reset === 1'b1) pulses++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic restart(input supv_option_t opt);
    i_option  <= opt;
    i_sys_rst <= 1'b1;
    repeat (6) @(posedge i_clk);
    check_val("reset readdata", 32'h0000_0000, o_avs_readdata);
    check_val("reset chip_reset", 32'h0000_0000, {31'h0, o_chip_reset});
    i_sys_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    pulses = 0;
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      i_lso_clk <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_lso_clk <= 1'b0;
      repeat (2) @(posedge i_clk);
    end
  endtask

  // Avalon-MM cycle: held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata);
    i_avs_address   <= addr;
    i_avs_writedata <= wdata;
    i_avs_write     <= wr;
    i_avs_read      <= ~wr;
    @(posedge i_clk iff (o_avs_waitrequest === 1'b0));
    rdata = o_avs_readdata;
    i_avs_write     <= 1'b0;
    i_avs_read      <= 1'b0;
    @(posedge i_clk);
  endtask

  initial begin
    for (int i = 0; i < 6; i++) begin
      restart(row_opt[i]);
      i_power_down <= row_pd[i];
      i_green_mode <= row_gm[i];
      ticks(PER - 1);
      check_val("early pulses", 32'h0000_0000, pulses);
      bus(1'b0, 12'h1_00, 32'h0, rd);
      check_val("count", row_run[i] ? PER - 1 : 0, {16'h0, rd[15:0]});
      ticks(1);
      check_val("pulses", {31'h0, row_run[i]}, pulses);
    end
    i_power_down <= 1'b0;
    i_green_mode <= 1'b0;
    restart(OPT_ENABLE);
    ticks(PER - 1);
    bus(1'b1, 12'h0_CC, 32'h0000_0033, rd);
    bus(1'b1, 12'h1_00, 32'h0000_005A, rd);
    i_avs_byteenable <= 4'h0;
    bus(1'b1, 12'h0_CC, 32'h0000_005A, rd);
    i_avs_byteenable <= 4'h1;
    bus(1'b0, 12'h1_00, 32'h0, rd);
    check_val("count after wrong key", PER - 1, {16'h0, rd[15:0]});
    check_val("pulses after wrong key", 32'h0000_0000, pulses);
    bus(1'b1, 12'h0_CC, 32'h0000_005A, rd); // Single clear point, main flow only
    bus(1'b0, 12'h1_00, 32'h0, rd);
    check_val("status after key", 32'h000D_0000, rd);
    bus(1'b0, 12'h0_CC, 32'h0, rd);
    check_val("clear register read", 32'h0000_0000, rd);
    bus(1'b0, 12'h0_04, 32'h0, rd);
    check_val("unmapped read", 32'h0000_0000, rd);
    ticks(PER - 1);
    check_val("pulses before overflow", 32'h0000_0000, pulses);
    ticks(1);
    check_val("pulses at overflow", 32'h0000_0001, pulses);
    ticks(PER);
    check_val("pulses after wrap", 32'h0000_0002, pulses);
    end_of_test();
  end
endmodule
`default_nettype wire

//--- src/program_watchdog.sv
// Program watchdog: Avalon-MM slave, option handling and chip reset generation
//
// Operation
// - The watchdog is a free-running binary up counter stepped only by its oscillator ticks.
// - Counter overflow raises a pulse that resets the whole microcontroller.
// - Overflow happens after 8192 oscillator periods, about 819.2 ms at 10 kHz.
// - With the disable option the watchdog stays idle and never resets the chip.
// - Enable option: counting runs in normal and slow modes and halts in power-down and green.
// - With the always-on option counting continues in every mode including power-down and green.
// - Writing 0x5A to the write-only 8-bit clear register (reset 0x00) restarts the count.
//
// The Avalon-MM register port is this design's own decision.
`include "program_watchdog_defines.svh"
`default_nettype none
module program_watchdog #(
  parameter int OVF_PERIODS = `SUPV_OVF_PERIODS,
  parameter int CW          = $clog2(OVF_PERIODS)
) (
  input  wire logic                              i_clk,
  input  wire logic                              i_sys_rst,
  input  wire logic                              i_lso_clk,
  input  wire program_watchdog_pkg::supv_option_t i_option,
  input  wire logic                              i_power_down,
  input  wire logic                              i_green_mode,
  input  wire logic [`SUPV_ADDR_W-1:0]           i_avs_address,
  input  wire logic                              i_avs_read,
  input  wire logic                              i_avs_write,
  input  wire logic [31:0]                       i_avs_writedata,
  input  wire logic [3:0]                        i_avs_byteenable,
  output logic [31:0]                            o_avs_readdata,
  output logic                                   o_avs_waitrequest,
  output logic                                   o_chip_reset
);
  import program_watchdog_pkg::*;

  localparam logic [CW-1:0] LAST = CW'(OVF_PERIODS - 1);

  typedef struct packed {
    logic         lso_prev;
    logic         ack;
    logic [31:0]  rdata;
    logic [7:0]   key;
    logic         chip_rst;
    logic         opt_valid;
    supv_option_t option;
  } wd_state_t;

  wd_state_t      state_q;
  wd_state_t      state_d;
  logic           lso_tick;
  logic           running;
  logic           low_power;
  logic           req;
  logic           wr_take;
  logic           key_hit;
  logic           clear;
  logic           overflow;
  logic [CW-1:0]  count;
  logic [31:0]    status;

  // Oscillator input is synchronous; its rising edge marks one period
  assign lso_tick  = i_lso_clk & ~state_q.lso_prev;
  assign low_power = i_power_down | i_green_mode;

  // Run gating by the build option, latched once after reset release
  always_comb begin
    running = 1'b0;
    if (state_q.opt_valid) begin
      unique case (state_q.option)
        OPT_DISABLE:   running = 1'b0;
        OPT_ENABLE:    running = ~low_power;
        OPT_ALWAYS_ON: running = 1'b1;
        default:       running = 1'b1;
      endcase
    end
  end

  // Build option checks: latched once after release, fixed until the next reset
  a_option_capture: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(state_q.opt_valid) |-> (state_q.option == $past(i_option)))
    else $error("build option not latched at release");

  a_option_frozen: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state_q.opt_valid |=> $stable(state_q.option))
    else $error("build option changed after latching");

  a_idle_unlatched: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !state_q.opt_valid |-> !running)
    else $error("counter runs before option latched");

  a_run_disable: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_q.option == OPT_DISABLE) |-> !running)
    else $error("disabled watchdog running");

  a_run_always: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_q.opt_valid && state_q.option == OPT_ALWAYS_ON) |-> running)
    else $error("always-on watchdog stopped");

  a_enable_steps: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_q.opt_valid && state_q.option == OPT_ENABLE && !low_power && lso_tick
     && !clear && count != LAST) |=> (count == CW'($past(count) + 1'b1)))
    else $error("enable option did not count in normal mode");

  a_enable_no_reset: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_q.option == OPT_ENABLE && low_power) |=> !o_chip_reset)
    else $error("chip reset from low power with enable option");

  // Bus: one wait cycle, write and read data at the edge of waitrequest low
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~state_q.ack;
  assign o_avs_readdata    = state_q.rdata;
  assign wr_take           = i_avs_write & state_q.ack;
  assign key_hit           = wr_take && (i_avs_address == `SUPV_CLEAR_KEY_OFS)
                             && i_avs_byteenable[0];
  assign clear             = key_hit && (i_avs_writedata[7:0] == `SUPV_KEY_VALUE);

  always_comb begin
    status = '0;
    status[`SUPV_STAT_COUNT_LSB +: `SUPV_STAT_COUNT_W] = `SUPV_STAT_COUNT_W'(count);
    status[`SUPV_STAT_OPT_LSB +: 2] = state_q.option;
    status[`SUPV_STAT_RUN_BIT]      = running;
    status[`SUPV_STAT_VALID_BIT]    = state_q.opt_valid;
  end

  // Bus handshake checks: one wait state per request, data from flip-flops
  a_wait_first_cycle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(req) |-> o_avs_waitrequest)
    else $error("fresh request answered without a wait cycle");

  a_idle_no_wait: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !req |-> !o_avs_waitrequest)
    else $error("waitrequest high without a request");

  a_ack_follows: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (req && !state_q.ack) |=> state_q.ack)
    else $error("request not answered");

  a_ack_drops: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (req && !o_avs_waitrequest) |=> !state_q.ack)
    else $error("answer stood longer than one cycle");

  a_status_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_avs_read && !o_avs_waitrequest && i_avs_address == `SUPV_STATUS_OFS)
    |-> (o_avs_readdata == $past(status)))
    else $error("status read data not from the request cycle");

  a_other_reads_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_avs_read && !o_avs_waitrequest && i_avs_address != `SUPV_STATUS_OFS)
    |-> (o_avs_readdata == '0))
    else $error("read of a non-status address not zero");

  a_readdata_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !req |=> $stable(o_avs_readdata))
    else $error("read data changed while idle");

  // Disable option holds the count at zero so no overflow can build up
  supervision_counter #(
    .OVF_PERIODS (OVF_PERIODS),
    .CW          (CW)
  ) u_counter (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_tick     (lso_tick),
    .i_run      (running),
    .i_clear    (clear | ~running & (state_q.option == OPT_DISABLE)),
    .o_count    (count),
    .o_overflow (overflow)
  );

  // Chip reset is a one-cycle registered pulse; the system reset clears this block
  always_comb begin
    state_d          = state_q;
    state_d.lso_prev = i_lso_clk;
    state_d.chip_rst = overflow;
    if (!state_q.opt_valid) begin
      state_d.opt_valid = 1'b1;
      state_d.option    = i_option;
    end
    if (req && !state_q.ack) begin
      state_d.ack   = 1'b1;
      state_d.rdata = '0;
      if (i_avs_read && i_avs_address == `SUPV_STATUS_OFS) begin
        state_d.rdata = status;
      end
    end else begin
      state_d.ack = 1'b0;
    end
    // Key is kept internally only; the register never reads back
    if (key_hit) begin
      state_d.key = i_avs_writedata[7:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q       <= '0;
      state_q.key   <= `SUPV_KEY_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_chip_reset = state_q.chip_rst;

  a_reset_from_ovf: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    overflow |=> o_chip_reset)
    else $error("overflow did not reset chip");

  a_reset_cause: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_chip_reset |-> ($past(count) == LAST) && $past(lso_tick) && $past(running))
    else $error("chip reset without overflow");

  a_disabled_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_q.opt_valid && state_q.option == OPT_DISABLE) |=> !o_chip_reset && count == '0)
    else $error("disabled watchdog active");

  a_low_power_halt: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_q.option == OPT_ENABLE && low_power && !clear) |=> $stable(count))
    else $error("counter moved in low power with enable option");

  a_always_counts: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_q.opt_valid && state_q.option == OPT_ALWAYS_ON && low_power && lso_tick
     && !clear && count != LAST) |=> (count == CW'($past(count) + 1'b1)))
    else $error("always-on counter halted");

  a_key_clears: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    clear |=> (count == '0) ##1 !o_chip_reset)
    else $error("key write did not restart counter");

  a_bad_key_keeps: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (key_hit && !clear && !lso_tick) |=> $stable(count) && !o_chip_reset)
    else $error("wrong key changed counter");

  a_bus_one_wait: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (req && o_avs_waitrequest) |=> !o_avs_waitrequest)
    else $error("bus answer later than one wait cycle");

  a_key_reads_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_avs_read && !o_avs_waitrequest && $past(i_avs_address) == `SUPV_CLEAR_KEY_OFS)
    |-> (o_avs_readdata == '0))
    else $error("write-only clear register read non-zero");

  // Counter, key and chip reset checks
  a_reset_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_chip_reset |=> !o_chip_reset)
    else $error("chip reset longer than one cycle");

  a_reset_needs_ovf: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_chip_reset) |-> $past(overflow))
    else $error("chip reset rose without overflow");

  a_wrap_after_ovf: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    overflow |=> (count == '0))
    else $error("counter did not wrap after overflow");

  a_count_bound: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    count <= LAST)
    else $error("counter beyond last period");

  a_idle_no_move: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!lso_tick && !clear) |=> $stable(count))
    else $error("counter moved without an oscillator tick");

  a_ovf_needs_run: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    overflow |-> running)
    else $error("overflow while counter halted");

  a_disable_no_ovf: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_q.option == OPT_DISABLE) |-> !overflow)
    else $error("overflow with disable option");

  a_no_reset_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    clear |=> !o_chip_reset)
    else $error("chip reset after key write");

  a_clear_wins: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (clear && lso_tick) |=> (count == '0))
    else $error("tick beat the clear key");

  a_clear_needs_key: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    clear |-> (i_avs_writedata[7:0] == `SUPV_KEY_VALUE))
    else $error("clear without the key value");

  a_clear_on_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    clear |-> (i_avs_write && !o_avs_waitrequest && i_avs_address == `SUPV_CLEAR_KEY_OFS))
    else $error("clear outside a completed key write");

  a_key_stored: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    key_hit |=> (state_q.key == $past(i_avs_writedata[7:0])))
    else $error("clear register did not take the write");

  a_key_kept: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !key_hit |=> $stable(state_q.key))
    else $error("clear register changed without a write");

  a_read_no_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_avs_read |-> !clear)
    else $error("read cleared the counter");

  a_stray_write_ignored: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_avs_write && i_avs_address != `SUPV_CLEAR_KEY_OFS) |-> !clear)
    else $error("write elsewhere cleared the counter");
endmodule
`default_nettype wire

//--- src/program_watchdog_defines.svh
// Constants of the program watchdog: offsets, field positions, key and timing
`ifndef PROGRAM_WATCHDOG_DEFINES_SVH
`define PROGRAM_WATCHDOG_DEFINES_SVH

`define SUPV_ADDR_W          12
`define SUPV_CLEAR_KEY_OFS   12'h0_0CC
`define SUPV_STATUS_OFS      12'h0_100
`define SUPV_KEY_VALUE       8'h5A
`define SUPV_KEY_RESET       8'h00
`define SUPV_OVF_PERIODS     8192
`define SUPV_LSO_FREQ_HZ     10000
`define SUPV_OVF_TIME_US     819200
`define SUPV_STAT_COUNT_LSB  0
`define SUPV_STAT_COUNT_W    16
`define SUPV_STAT_OPT_LSB    16
`define SUPV_STAT_RUN_BIT    18
`define SUPV_STAT_VALID_BIT  19

`endif

//--- src/program_watchdog_pkg.sv
// Types shared by the program watchdog files
`default_nettype none
package program_watchdog_pkg;
  typedef enum logic [1:0] {
    OPT_DISABLE,
    OPT_ENABLE,
    OPT_ALWAYS_ON
  } supv_option_t;
endpackage
`default_nettype wire

//--- src/supervision_counter.sv
// Free-running up counter of low-speed oscillator periods with overflow pulse
`default_nettype none
module supervision_counter #(
  parameter int OVF_PERIODS = 8192,
  parameter int CW          = $clog2(OVF_PERIODS)
) (
  input  wire logic          i_clk,
  input  wire logic          i_sys_rst,
  input  wire logic          i_tick,
  input  wire logic          i_run,
  input  wire logic          i_clear,
  output logic [CW-1:0]      o_count,
  output logic               o_overflow
);
  import program_watchdog_pkg::*;

  localparam logic [CW-1:0] LAST = CW'(OVF_PERIODS - 1);

  typedef struct packed {
    logic [CW-1:0] count;
  } cnt_state_t;

  cnt_state_t state_q;
  cnt_state_t state_d;
  logic       step;

  // Advance only on an oscillator period while allowed to run
  assign step       = i_tick & i_run & ~i_clear;
  assign o_overflow = step & (state_q.count == LAST);
  assign o_count    = state_q.count;

  always_comb begin
    state_d = state_q;
    if (i_clear) begin
      state_d.count = '0;
    end else if (step) begin
      state_d.count = (state_q.count == LAST) ? '0 : CW'(state_q.count + 1'b1);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  a_clear_restarts: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_clear |=> (o_count == '0))
    else $error("counter not zero after clear");

  a_count_steps: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_tick && i_run && !i_clear && o_count != LAST) |=> (o_count == CW'($past(o_count) + 1'b1)))
    else $error("counter did not step on tick");

  a_hold_no_tick: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!i_clear && !(i_tick && i_run)) |=> $stable(o_count))
    else $error("counter moved without a running tick");

  a_wrap_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_overflow |-> (o_count == LAST) ##1 (o_count == '0))
    else $error("overflow not at last count or no wrap");
endmodule
`default_nettype wire
